// [pkg/smb_aux_pkg.sv]
/*
 * Constants shared by the DMA hand-off, packet check and SMBus status block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package smb_aux_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned TIMEOUT_MS = 35;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned SCL_MIN_HZ = 10_000;
   localparam int unsigned SCL_HALF_MAX_CYC = CLK_HZ / (2 * SCL_MIN_HZ);

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] CTRL0_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] CTRL1_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] STAT0_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] STAT1_OFS = 8'h0c;
   localparam logic [ADDR_W-1:0] CLKDIV_OFS = 8'h10;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Control word 0 fields.
   localparam int C0_SMB_EN = 1;
   localparam int C0_ROLE = 3;
   localparam int C0_ARP = 4;
   localparam int C0_CRC_EN = 5;
   localparam int C0_ACK_EN = 10;
   localparam int C0_STOP = 9;
   localparam int C0_CRC_XFER = 12;
   localparam int C0_ALERT = 13;
   localparam logic [15:0] CTRL0_RST = 16'h0000;
   localparam logic [15:0] CTRL0_MASK = 16'h363a;

   // Control word 1 fields.
   localparam int C1_ERR_IE = 8;
   localparam int C1_EV_IE = 9;
   localparam int C1_BUF_IE = 10;
   localparam int C1_DMA_ON = 11;
   localparam int C1_DMA_LAST = 12;
   localparam logic [15:0] CTRL1_RST = 16'h0000;
   localparam logic [15:0] CTRL1_MASK = 16'h1f00;

   // Status word 0 fields.
   localparam int S0_START = 0;
   localparam int S0_ADDR = 1;
   localparam int S0_BYTE = 2;
   localparam int S0_HDR10 = 3;
   localparam int S0_STOP = 4;
   localparam int S0_RXFULL = 6;
   localparam int S0_TXEMPTY = 7;
   localparam int S0_BUSERR = 8;
   localparam int S0_ARB = 9;
   localparam int S0_ACK = 10;
   localparam int S0_OUR = 11;
   localparam int S0_CRC = 12;
   localparam int S0_TOUT = 14;
   localparam int S0_ALERT = 15;
   localparam logic [15:0] EV_MASK = 16'h001f;
   localparam logic [15:0] ERR_MASK = 16'hdf00;

   // Status word 1 fields.
   localparam int S1_DEFAULT = 5;
   localparam int S1_HOST = 6;
   localparam int S1_CRC_LSB = 8;

   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam int TOUT_W = 20;
   localparam int DIV_W = 11;
   localparam logic [DIV_W-1:0] CLKDIV_RST = 11'h07d;
endpackage

// [verilog/smb_aux.sv]
/*
 * DMA request hand-off, CRC-8 packet check, SMBus timeout, clock floor,
 * address-resolution and alert flags, and the event and error status of a
 * two-wire bus interface, reached over AXI4-Lite.
 * Assumes a byte engine on the same clock that reports its events as one-cycle
 * pulses and its buffer states as levels; bus pins arrive asynchronously.
 */
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module smb_aux #(
   parameter int unsigned TIMEOUT_CYCLES = smb_aux_pkg::TIMEOUT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [smb_aux_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [smb_aux_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [smb_aux_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [smb_aux_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic smba_in,
   output logic smba_o,
   output logic smba_oe_n,
   input wire logic tx_buf_empty,
   input wire logic rx_buf_full,
   input wire logic start_sent,
   input wire logic addr_phase_done,
   input wire logic header10_sent,
   input wire logic byte_complete,
   input wire logic bus_error,
   input wire logic arbitration_lost,
   input wire logic over_under_run,
   input wire logic ack_missing,
   input wire logic byte_stb,
   input wire logic [7:0] byte_data,
   input wire logic byte_is_crc,
   input wire logic byte_is_rx,
   input wire logic addr_is_host_header,
   input wire logic addr_is_default,
   input wire logic dma_done_signal,
   output logic dma_tx_req,
   output logic dma_rx_req,
   output logic ack_out,
   output logic stop_req,
   output logic crc_send,
   output logic [7:0] crc_value,
   output logic scl_half_tick,
   output logic ev_irq,
   output logic err_irq
);
   import smb_aux_pkg::*;

   typedef enum logic [1:0] {
      LINE_IDLE = 2'b00,
      LINE_BUSY = 2'b01,
      LINE_TOUT = 2'b10
   } line_state_t;

   localparam logic [TOUT_W-1:0] TOUT_LIMIT = TOUT_W'(TIMEOUT_CYCLES);
   localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(SCL_HALF_MAX_CYC);

   logic [15:0] ctrl0_q;
   logic [15:0] ctrl1_q;
   logic [15:0] flags_q;
   logic [1:0] arp_q;
   logic [7:0] crc_q;
   logic [DIV_W-1:0] clkdiv_q;
   logic [DIV_W-1:0] divcnt_q;
   logic [TOUT_W-1:0] tout_cnt_q;
   line_state_t line_q;
   logic [2:0] scl_sync_q;
   logic [2:0] sda_sync_q;
   logic [2:0] smba_sync_q;
   logic aw_have_q;
   logic w_have_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [3:0] wstrb_q;
   logic last_nack_q;
   logic start_det;
   logic stop_det;
   logic alert_fall;
   logic wr_fire;
   logic tout_hit;
   logic [15:0] flag_set;
   logic [15:0] flag_clr;
   logic [15:0] wmask;
   logic [15:0] stat0_view;
   logic [15:0] rd_word;
   logic rd_hit;
   logic wr_hit;
   logic [DIV_W-1:0] div_wr;

   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   // Pins pass two flip-flops; the third stage only feeds edge detection.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_sync_q <= 3'h7;
         sda_sync_q <= 3'h7;
         smba_sync_q <= 3'h7;
      end else begin
         scl_sync_q <= {scl_sync_q[1:0], scl_in};
         sda_sync_q <= {sda_sync_q[1:0], sda_in};
         smba_sync_q <= {smba_sync_q[1:0], smba_in};
      end
   end

   assign start_det = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[2] && !sda_sync_q[1];
   assign stop_det = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[2] && sda_sync_q[1];
   assign alert_fall = smba_sync_q[2] && !smba_sync_q[1];

   // Write channel of the register bus.
   assign wr_fire = aw_have_q && w_have_q && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_have_q <= 1'b0;
         waddr_q <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_have_q <= 1'b1;
         waddr_q <= awaddr;
      end else begin
         if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         awready <= !aw_have_q && !bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_have_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_have_q <= 1'b1;
         wdata_q <= wdata;
         wstrb_q <= wstrb;
      end else begin
         if (wr_fire) begin
            w_have_q <= 1'b0;
         end
         wready <= !w_have_q && !bvalid;
      end
   end

   assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wr_hit = waddr_q == CTRL0_OFS || waddr_q == CTRL1_OFS || waddr_q == STAT0_OFS ||
                   waddr_q == STAT1_OFS || waddr_q == CLKDIV_OFS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // Control word 0, with hardware clears on the CRC and STOP requests and a hardware set on STOP.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl0_q <= CTRL0_RST;
      end else begin
         if (wr_fire && waddr_q == CTRL0_OFS) begin
            ctrl0_q <= (ctrl0_q & ~(wmask & CTRL0_MASK)) | (wdata_q[15:0] & wmask & CTRL0_MASK);
         end
         if ((byte_stb && byte_is_crc) || start_det || stop_det) begin
            ctrl0_q[C0_CRC_XFER] <= 1'b0;
         end
         if (stop_det) begin
            ctrl0_q[C0_STOP] <= 1'b0;
         end
         if (tout_hit) begin
            ctrl0_q[C0_STOP] <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl1_q <= CTRL1_RST;
      end else if (wr_fire && waddr_q == CTRL1_OFS) begin
         ctrl1_q <= (ctrl1_q & ~(wmask & CTRL1_MASK)) | (wdata_q[15:0] & wmask & CTRL1_MASK);
      end
   end

   // The clock divider is clamped so the bus clock never drops below the floor.
   assign div_wr = (wdata_q[DIV_W-1:0] > DIV_MAX) ? DIV_MAX :
                   (wdata_q[DIV_W-1:0] == '0) ? DIV_W'(1) : wdata_q[DIV_W-1:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clkdiv_q <= CLKDIV_RST;
      end else if (wr_fire && waddr_q == CLKDIV_OFS && wstrb_q[0] && wstrb_q[1]) begin
         clkdiv_q <= div_wr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         divcnt_q <= '0;
         scl_half_tick <= 1'b0;
      end else if (divcnt_q + DIV_W'(1) >= clkdiv_q) begin
         divcnt_q <= '0;
         scl_half_tick <= 1'b1;
      end else begin
         divcnt_q <= divcnt_q + DIV_W'(1);
         scl_half_tick <= 1'b0;
      end
   end

   // Clock-low watchdog for SMBus mode.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_q <= LINE_IDLE;
         tout_cnt_q <= '0;
      end else begin
         case (line_q)
            LINE_IDLE: begin
               tout_cnt_q <= '0;
               if (ctrl0_q[C0_SMB_EN] && !scl_sync_q[1]) begin
                  line_q <= LINE_BUSY;
               end
            end
            LINE_BUSY: begin
               if (!ctrl0_q[C0_SMB_EN] || scl_sync_q[1]) begin
                  line_q <= LINE_IDLE;
               end else if (tout_cnt_q + TOUT_W'(1) >= TOUT_LIMIT) begin
                  line_q <= LINE_TOUT;
               end else begin
                  tout_cnt_q <= tout_cnt_q + TOUT_W'(1);
               end
            end
            LINE_TOUT: begin
               if (scl_sync_q[1] || !ctrl0_q[C0_SMB_EN]) begin
                  line_q <= LINE_IDLE;
               end
            end
            default: line_q <= LINE_IDLE;
         endcase
      end
   end

   assign tout_hit = line_q == LINE_BUSY && ctrl0_q[C0_SMB_EN] && !scl_sync_q[1] &&
                     tout_cnt_q + TOUT_W'(1) >= TOUT_LIMIT;

   // CRC over every bus byte except CRC bytes, restarted on each START.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crc_q <= CRC_INIT;
      end else if (start_det || !ctrl0_q[C0_CRC_EN]) begin
         crc_q <= CRC_INIT;
      end else if (byte_stb && !byte_is_crc) begin
         crc_q <= crc8_step(crc_q, byte_data);
      end
   end

   // Sticky flags; a set in the same cycle as a clear wins.
   always_comb begin
      flag_set = '0;
      flag_set[S0_START] = start_sent;
      flag_set[S0_ADDR] = addr_phase_done;
      flag_set[S0_BYTE] = byte_complete;
      flag_set[S0_HDR10] = header10_sent;
      flag_set[S0_STOP] = stop_det;
      flag_set[S0_BUSERR] = bus_error;
      flag_set[S0_ARB] = arbitration_lost;
      flag_set[S0_OUR] = over_under_run;
      flag_set[S0_ACK] = ack_missing;
      flag_set[S0_CRC] = ctrl0_q[C0_CRC_EN] && byte_stb && byte_is_rx && byte_is_crc &&
                         byte_data != crc_q;
      flag_set[S0_TOUT] = tout_hit;
      flag_set[S0_ALERT] = ctrl0_q[C0_SMB_EN] && ctrl0_q[C0_ROLE] && alert_fall;
   end

   assign flag_clr = (wr_fire && waddr_q == STAT0_OFS) ? (wdata_q[15:0] & wmask) : 16'h0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= '0;
      end else begin
         flags_q <= ((flags_q & ~flag_clr) | flag_set) & (EV_MASK | ERR_MASK);
      end
   end

   // Address-resolution flags for the selected SMBus role.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arp_q <= 2'b00;
      end else begin
         if (wr_fire && waddr_q == STAT1_OFS && wstrb_q[0]) begin
            arp_q <= arp_q & ~wdata_q[S1_HOST:S1_DEFAULT];
         end
         if (ctrl0_q[C0_SMB_EN] && ctrl0_q[C0_ARP]) begin
            if (ctrl0_q[C0_ROLE] && addr_is_host_header) begin
               arp_q[1] <= 1'b1;
            end
            if (!ctrl0_q[C0_ROLE] && addr_is_default) begin
               arp_q[0] <= 1'b1;
            end
         end
      end
   end

   // Final-transfer marking from the DMA done input.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_nack_q <= 1'b0;
      end else if (start_det || stop_det) begin
         last_nack_q <= 1'b0;
      end else if (dma_done_signal && ctrl1_q[C1_DMA_ON] && ctrl1_q[C1_DMA_LAST]) begin
         last_nack_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_tx_req <= 1'b0;
         dma_rx_req <= 1'b0;
         ack_out <= 1'b0;
         stop_req <= 1'b0;
         crc_send <= 1'b0;
         crc_value <= CRC_INIT;
      end else begin
         dma_tx_req <= ctrl1_q[C1_DMA_ON] && tx_buf_empty && !crc_send;
         dma_rx_req <= ctrl1_q[C1_DMA_ON] && rx_buf_full;
         ack_out <= ctrl0_q[C0_ACK_EN] && !last_nack_q;
         stop_req <= ctrl0_q[C0_STOP];
         crc_send <= ctrl0_q[C0_CRC_EN] && ctrl0_q[C0_CRC_XFER] &&
                     (!ctrl1_q[C1_DMA_ON] || dma_done_signal || crc_send);
         crc_value <= crc_q;
      end
   end

   // Alert pin: driven low while SMBus mode is on and software issues an alert.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         smba_o <= 1'b1;
         smba_oe_n <= 1'b1;
      end else begin
         smba_o <= 1'b0;
         smba_oe_n <= !(ctrl0_q[C0_SMB_EN] && ctrl0_q[C0_ALERT]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_irq <= 1'b0;
         err_irq <= 1'b0;
      end else begin
         ev_irq <= ctrl1_q[C1_EV_IE] && ((|(flags_q & EV_MASK)) || (|arp_q) ||
                   (ctrl1_q[C1_BUF_IE] && (tx_buf_empty || rx_buf_full)));
         err_irq <= ctrl1_q[C1_ERR_IE] && (|(flags_q & ERR_MASK));
      end
   end

   // Read channel of the register bus.
   always_comb begin
      stat0_view = flags_q;
      stat0_view[S0_RXFULL] = rx_buf_full;
      stat0_view[S0_TXEMPTY] = tx_buf_empty;
   end

   always_comb begin
      rd_word = 16'h0000;
      rd_hit = 1'b1;
      case (araddr)
         CTRL0_OFS: rd_word = ctrl0_q;
         CTRL1_OFS: rd_word = ctrl1_q;
         STAT0_OFS: rd_word = stat0_view;
         STAT1_OFS: rd_word = {crc_q, 1'b0, arp_q, 5'h00};
         CLKDIV_OFS: rd_word = {5'h00, clkdiv_q};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {16'h0000, rd_word};
         rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else begin
         arready <= !rvalid;
      end
   end
endmodule

// [sim/smb_aux_properties.sv]
/* Checker on the smb_aux ports: bus handshakes, DMA requests, clock floor, alert pin.
   Bound into every smb_aux; aclk clocks everything and aresetn resets it. */
`timescale 1ns/1ps
module smb_aux_properties
   import smb_aux_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = smb_aux_pkg::TIMEOUT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [smb_aux_pkg::DATA_W-1:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic tx_buf_empty,
   input wire logic rx_buf_full,
   input wire logic dma_tx_req,
   input wire logic dma_rx_req,
   input wire logic smba_o,
   input wire logic crc_send,
   input wire logic scl_half_tick
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [10:0] gap_q;

   // Counts the cycles since the last half-period tick.
   always_ff @(posedge aclk) begin
      if (!aresetn || scl_half_tick) begin
         gap_q <= 11'h000;
      end else begin
         gap_q <= gap_q + 11'h001;
      end
   end

   a_bvalid_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped early");
   a_rvalid_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed early");
   a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write answer late");
   a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
   a_write_refused: assert property (bvalid |-> !awready && !wready) else $error("write taken during answer");
   a_read_refused: assert property (rvalid |-> !arready) else $error("read taken during answer");
   a_tx_req_cause: assert property (!tx_buf_empty |=> !dma_tx_req) else $error("tx request without empty buffer");
   a_rx_req_cause: assert property (!rx_buf_full |=> !dma_rx_req) else $error("rx request without full buffer");
   a_clock_floor: assert property (gap_q <= SCL_HALF_MAX_CYC) else $error("bus clock below minimum rate");
   a_alert_low: assert property ($past(aresetn) |-> !smba_o) else $error("alert pin drives high");

   c_dma_tx: cover property (dma_tx_req);
   c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
   c_crc_send: cover property (crc_send);
endmodule

bind smb_aux smb_aux_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.*);

// [sim/smb_bus_model.sv]
/* Far side of the two-wire bus: open-drain SCL, SDA and alert with pull-ups.
   The bench calls its tasks; SCL stands high outside frames. */
`timescale 1ns/1ps
module smb_bus_model (
   output logic scl,
   output logic sda,
   output logic smba
);
   localparam int HALF = 160;

   initial begin
      scl = 1'b1;
      sda = 1'b1;
      smba = 1'b1;
   end

   task automatic start_cond();
      #1 sda = 1'b0;
      #HALF scl = 1'b0;
      #HALF sda = 1'b1;
      #HALF scl = 1'b1;
   endtask

   task automatic stop_cond();
      #1 scl = 1'b0;
      #HALF sda = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda = 1'b1;
   endtask

   task automatic hold_low(input int ns);
      #1 scl = 1'b0;
      #ns scl = 1'b1;
      #HALF;
   endtask

   task automatic alert(input logic on);
      #1 smba = !on;
   endtask
endmodule

// [sim/test_smb_aux.sv]
/* Self-checking bench for smb_aux: AXI4-Lite master, byte-engine and DMA pulses,
   far-side bus model. Expected bus answers queue up and are checked on arrival. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_smb_aux;
   import smb_aux_pkg::*;
   typedef struct {logic [33:0] e; logic [33:0] m;} note_t;
   localparam logic [31:0] SMB = 32'h1 << C0_SMB_EN, HOST = 32'h1 << C0_ROLE, ARP = 32'h1 << C0_ARP;
   localparam logic [31:0] CEN = 32'h1 << C0_CRC_EN, ACK = 32'h1 << C0_ACK_EN, XF = 32'h1 << C0_CRC_XFER;
   note_t q[$];
   note_t nt;
   logic [33:0] got;
   int failures = 0, cmp_count = 0;
   int pos[8] = '{S0_START, S0_ADDR, S0_BYTE, S0_HDR10, S0_BUSERR, S0_ARB, S0_OUR, S0_ACK};
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, byte_data = 8'h00, crc_value;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic scl_in, sda_in, smba_in, smba_o, smba_oe_n, tx_buf_empty = 0, rx_buf_full = 0;
   logic byte_stb = 0, byte_is_crc = 0, byte_is_rx = 0, dma_tx_req, dma_rx_req, ack_out, stop_req, crc_send;
   logic scl_half_tick, ev_irq, err_irq;
   logic [10:0] pl = 11'h000;
   wire start_sent, addr_phase_done, header10_sent, byte_complete, bus_error, arbitration_lost;
   wire over_under_run, ack_missing, addr_is_host_header, addr_is_default, dma_done_signal;
   assign {dma_done_signal, addr_is_default, addr_is_host_header, ack_missing, over_under_run, arbitration_lost,
      bus_error, header10_sent, byte_complete, addr_phase_done, start_sent} = pl;

   smb_aux #(.TIMEOUT_CYCLES(64)) uut (.*);
   smb_bus_model bus (.scl(scl_in), .sda(sda_in), .smba(smba_in));

   always #20 aclk = ~aclk;

   always @(posedge aclk) begin
      if ((bvalid && bready) || (rvalid && rready)) begin
         nt = q.pop_front();
         got = bvalid ? {bresp, 32'h0} : {rresp, rdata};
         `CHK("bus answer", nt.e, got & nt.m)
      end
   end

   task automatic end_of_test();
      if (failures == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      int n;
      q.push_back('{{r, 32'h0}, {2'b11, 32'h0}});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 64);
      bready <= 1'b0;
      @(posedge aclk);
      if (n >= 64) begin
         failures++;
         end_of_test();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] r = RESP_OKAY);
      int n;
      q.push_back('{{r, e & m}, {2'b11, m}});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 64);
      rready <= 1'b0;
      @(posedge aclk);
      if (n >= 64) begin
         failures++;
         end_of_test();
      end
   endtask

   task automatic rdb(input logic [7:0] a, input int p, input logic v);
      rd(a, v ? 32'h1 << p : 32'h0, 32'h1 << p);
   endtask

   task automatic pulse(input int i);
      pl <= 11'h001 << i;
      @(posedge aclk);
      pl <= 11'h000;
      @(posedge aclk);
   endtask

   task automatic send_byte(input logic [7:0] b, input logic cr, input logic rx);
      byte_data <= b;
      byte_is_crc <= cr;
      byte_is_rx <= rx;
      byte_stb <= 1'b1;
      @(posedge aclk);
      byte_stb <= 1'b0;
      @(posedge aclk);
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      repeat (8) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
      return x;
   endfunction

   initial begin
      repeat (100000) @(posedge aclk);
      failures++;
      end_of_test();
   end

   initial begin
      int v, i, n;
      logic [7:0] c;
      v = $urandom(61857);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(CTRL0_OFS, {16'h0, CTRL0_RST}, 32'hffffffff);
      rd(CTRL1_OFS, {16'h0, CTRL1_RST}, 32'hffffffff);
      rd(CLKDIV_OFS, {21'h0, CLKDIV_RST}, 32'hffffffff);
      rd(8'h14, 32'h0, 32'h0, RESP_SLVERR);
      wr(8'h14, 32'h0, RESP_SLVERR);
      wr(CLKDIV_OFS, 32'h0);
      rd(CLKDIV_OFS, 32'h1, 32'hffffffff);
      wr(CLKDIV_OFS, 32'h7d0);
      rd(CLKDIV_OFS, SCL_HALF_MAX_CYC, 32'hffffffff);
      v = $urandom % 1250 + 1;
      wr(CLKDIV_OFS, v);
      for (n = 0; n < 2; n++) begin
         i = 0;
         @(posedge aclk);
         while (!scl_half_tick && i < 2600) begin
            @(posedge aclk);
            i++;
         end
      end
      `CHK("tick gap", v - 1, i)
      tx_buf_empty <= 1'b1;
      rx_buf_full <= 1'b1;
      repeat (3) @(posedge aclk);
      `CHK("tx req off", 1'b0, dma_tx_req)
      wr(CTRL1_OFS, 32'h1 << C1_DMA_ON);
      repeat (3) @(posedge aclk);
      `CHK("tx req", 1'b1, dma_tx_req)
      `CHK("rx req", 1'b1, dma_rx_req)
      tx_buf_empty <= 1'b0;
      rx_buf_full <= 1'b0;
      wr(CTRL1_OFS, (32'h1 << C1_ERR_IE) | (32'h1 << C1_EV_IE));
      for (i = 0; i < 8; i++) begin
         pulse(i);
         repeat (2) @(posedge aclk);
         `CHK("irq", 1'b1, (i < 4) ? ev_irq : err_irq)
         rdb(STAT0_OFS, pos[i], 1'b1);
         wr(STAT0_OFS, 32'h1 << pos[i]);
         rdb(STAT0_OFS, pos[i], 1'b0);
      end
      wr(CTRL0_OFS, SMB | HOST | ARP);
      pulse(8);
      pulse(9);
      rd(STAT1_OFS, 32'h1 << S1_HOST, 32'h60);
      wr(STAT1_OFS, 32'h60);
      wr(CTRL0_OFS, SMB | ARP);
      pulse(8);
      pulse(9);
      rd(STAT1_OFS, 32'h1 << S1_DEFAULT, 32'h60);
      wr(CTRL0_OFS, SMB | HOST);
      bus.alert(1'b1);
      repeat (8) @(posedge aclk);
      bus.alert(1'b0);
      rdb(STAT0_OFS, S0_ALERT, 1'b1);
      wr(CTRL0_OFS, SMB | (32'h1 << C0_ALERT));
      repeat (3) @(posedge aclk);
      `CHK("alert drive", 1'b0, smba_oe_n)
      wr(CTRL0_OFS, SMB);
      bus.hold_low(1600);
      @(posedge aclk);
      rdb(STAT0_OFS, S0_TOUT, 1'b0);
      bus.hold_low(4000);
      @(posedge aclk);
      rdb(STAT0_OFS, S0_TOUT, 1'b1);
      rdb(CTRL0_OFS, C0_STOP, 1'b1);
      `CHK("stop req", 1'b1, stop_req)
      bus.stop_cond();
      repeat (4) @(posedge aclk);
      rdb(CTRL0_OFS, C0_STOP, 1'b0);
      rdb(STAT0_OFS, S0_STOP, 1'b1);
      wr(CTRL0_OFS, SMB | CEN);
      bus.start_cond();
      @(posedge aclk);
      c = 8'h00;
      for (i = 0; i < 5; i++) begin
         v = $urandom;
         send_byte(v[7:0], 1'b0, 1'b1);
         c = crc8(c, v[7:0]);
      end
      @(posedge aclk);
      `CHK("crc value", c, crc_value)
      rd(STAT1_OFS, {16'h0, c, 8'h00}, 32'hff00);
      send_byte(c, 1'b1, 1'b1);
      rdb(STAT0_OFS, S0_CRC, 1'b0);
      send_byte(~c, 1'b1, 1'b1);
      rdb(STAT0_OFS, S0_CRC, 1'b1);
      rdb(STAT0_OFS, S0_CRC, 1'b1);
      wr(STAT0_OFS, 32'h1 << S0_CRC);
      rdb(STAT0_OFS, S0_CRC, 1'b0);
      wr(CTRL0_OFS, SMB | CEN | XF);
      repeat (2) @(posedge aclk);
      `CHK("crc send", 1'b1, crc_send)
      send_byte(c, 1'b1, 1'b0);
      rdb(CTRL0_OFS, C0_CRC_XFER, 1'b0);
      `CHK("crc send end", 1'b0, crc_send)
      wr(CTRL0_OFS, SMB | CEN | XF);
      bus.start_cond();
      @(posedge aclk);
      rdb(CTRL0_OFS, C0_CRC_XFER, 1'b0);
      wr(CTRL1_OFS, (32'h1 << C1_DMA_ON) | (32'h1 << C1_DMA_LAST));
      wr(CTRL0_OFS, SMB | CEN | ACK | XF);
      repeat (2) @(posedge aclk);
      `CHK("ack", 1'b1, ack_out)
      `CHK("crc send dma", 1'b0, crc_send)
      pulse(10);
      repeat (2) @(posedge aclk);
      `CHK("nack last", 1'b0, ack_out)
      `CHK("crc send dma", 1'b1, crc_send)
      bus.stop_cond();
      repeat (5) @(posedge aclk);
      `CHK("ack after stop", 1'b1, ack_out)
      rdb(CTRL0_OFS, C0_CRC_XFER, 1'b0);
      wr(CTRL0_OFS, SMB | CEN);
      `CHK("ack off", 1'b0, ack_out)
      pulse(1);
      rdb(STAT0_OFS, S0_ADDR, 1'b1);
      wr(STAT0_OFS, 32'h1 << S0_ADDR);
      pulse(10);
      wr(CTRL0_OFS, SMB | CEN | (32'h1 << C0_STOP));
      `CHK("stop req sw", 1'b1, stop_req)
      end_of_test();
   end
endmodule
